// File: logic/rfc_pkg.sv
package rfc_pkg;

  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int          RFC_CNT_W     = 24;
  localparam logic [23:0] RFC_CNT_ZERO  = 24'h000000;
  localparam logic [23:0] RFC_CNT_ONES  = 24'hFFFFFF;
  localparam logic [23:0] RFC_CNT_ONE   = 24'h000001;
  localparam logic [23:0] RFC_MC_RST    = 24'h000000;
  localparam logic [23:0] RFC_TC_RST    = 24'h000000;
  localparam logic [1:0]  RFC_MODE_DC   = 2'h0;
  localparam logic [1:0]  RFC_MODE_AC   = 2'h1;
  localparam logic [1:0]  RFC_DIV_RST   = 2'h0;
  localparam logic [7:0]  RFC_DIVCNT_RST = 8'h00;

  // Phase of the converter
  typedef enum logic [1:0] {
    RFC_IDLE,
    RFC_REF,
    RFC_SEN_A,
    RFC_SEN_B
  } rfc_phase_t;

  // Event pulses, one bit per flag
  typedef struct packed {
    logic ref_done;
    logic sensor_a_done;
    logic sensor_b_done;
    logic meas_ovf;
    logic timebase_ovf;
  } rfc_evt_t;

  // Software preset writes for the measurement and time base counters
  typedef struct packed {
    logic        mc_wr;
    logic [23:0] mc_data;
    logic        tc_wr;
    logic [23:0] tc_data;
  } rfc_preset_t;

endpackage : rfc_pkg

// File: logic/rfc_ctrl.sv
`timescale 1ns/1ps
module rfc_ctrl
  import rfc_pkg::*;
#(
  parameter int DIV_W = 8                   // Width of operating clock divider
) (
  input  wire logic              clk,                  // System clock, 125 MHz
  input  wire logic              sys_rst,              // Async reset, active high
  input  wire logic              module_enable,        // Converter enable
  input  wire logic [1:0]        op_clock_source_sel,  // Operating clock source
  input  wire logic [1:0]        op_clock_divider_sel, // Operating clock divider
  input  wire logic              debug_run_en,         // Keep running in debug halt
  input  wire logic              cpu_debug_halt,       // Processor halted for debug
  input  wire logic [1:0]        osc_mode_sel,         // DC or AC drive
  input  wire logic              ext_clock_input_en,   // Count external pin
  input  wire logic              rc_osc_clock,         // RC oscillator output, async
  input  wire logic              osc_input_pin,        // External pulse pin, async
  input  wire logic              ref_trig_set,         // Pulse: start reference
  input  wire logic              sena_trig_set,        // Pulse: start sensor A
  input  wire logic              senb_trig_set,        // Pulse: start sensor B
  input  wire logic              trig_abort,           // Pulse: write 0 to trigger
  input  wire rfc_preset_t       preset,               // Counter preset writes
  input  wire rfc_evt_t          flag_clear,           // Write-one-to-clear strobes
  input  wire rfc_evt_t          irq_enable,           // Per-flag enables
  output logic                   ref_osc_trigger,      // Reference running
  output logic                   sensor_a_trigger,     // Sensor A running
  output logic                   sensor_b_trigger,     // Sensor B running
  output logic                   ref_resistor_pin,     // Drive reference element
  output logic                   sensor_a_pin,         // Drive sensor A
  output logic                   sensor_b_pin,         // Drive sensor B
  output logic                   osc_monitor_out_pin,  // Oscillation monitor
  output logic [RFC_CNT_W-1:0]   measurement_counter,  // Measurement count
  output logic [RFC_CNT_W-1:0]   timebase_counter,     // Time base count
  output rfc_evt_t               flags,                // Sticky event flags
  output logic                   irq                   // Interrupt request
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Both pins idle low, so the reset value of each chain matches its pin
  logic [2:0] osc_sync;
  logic [2:0] pin_sync;
  logic       osc_count_clock;
  logic       osc_edge;

  // Third stage only serves the edge detector; first stage stays private
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_sync <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      osc_sync <= {osc_sync[1:0], rc_osc_clock};
      pin_sync <= {pin_sync[1:0], osc_input_pin};
    end
  end

  // Source mux for the counted clock
  assign osc_count_clock = ext_clock_input_en ? pin_sync[1] : osc_sync[1];
  assign osc_edge = ext_clock_input_en ? (pin_sync[1] & ~pin_sync[2])
                                       : (osc_sync[1] & ~osc_sync[2]);

  // ----------------------------------------
  // Operating clock enable
  // ----------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic             clk_run;
  logic             timebase_op_clock;
  logic [DIV_W-1:0] div_mask;

  // Divider ratio 1,2,4,8 times source; source picks a base prescale
  function automatic logic [DIV_W-1:0] rfc_mask(input logic [1:0] src, input logic [1:0] dv);
    logic [3:0] sh;
    sh = {2'h0, src} + {2'h0, dv};
    rfc_mask = DIV_W'((1 << sh) - 1);
  endfunction : rfc_mask

  assign div_mask = rfc_mask(op_clock_source_sel, op_clock_divider_sel);
  assign clk_run  = module_enable & (debug_run_en | ~cpu_debug_halt);

  // Prescale keeps its phase through a halt instead of restarting
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_cnt <= '0;
    else if (!clk_run)
      div_cnt <= div_cnt;                   // Hold while gated, state kept
    else if ((div_cnt & div_mask) == div_mask)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + DIV_W'(1);
  end

  assign timebase_op_clock = clk_run & ((div_cnt & div_mask) == div_mask);

  // ----------------------------------------
  // Debug freeze
  // ----------------------------------------
  logic frozen;

  // Halt without run keeps counters and the monitor pin as the debugger left them
  assign frozen = cpu_debug_halt & ~debug_run_en;

  // ----------------------------------------
  // Phase control
  // ----------------------------------------
  rfc_phase_t phase;
  logic       mc_wrap;
  logic       tc_wrap;
  logic       tc_hit_zero;
  logic       mc_tick;
  logic       tc_tick;
  logic       sen_b_ok;
  logic       start_ok;

  // Phase is internal; software sees it through the trigger bits a cycle late
  // Oscillation edges also freeze in a gated debug halt
  assign mc_tick     = osc_edge & clk_run & (phase != RFC_IDLE);
  assign tc_tick     = timebase_op_clock & (phase != RFC_IDLE);
  assign mc_wrap     = mc_tick & (measurement_counter == RFC_CNT_ONES);
  assign tc_wrap     = tc_tick & (phase == RFC_REF) & (timebase_counter == RFC_CNT_ONES);
  // A sensor run from a zero time base ends on its first tick, never hangs
  assign tc_hit_zero = tc_tick & ((phase == RFC_SEN_A) | (phase == RFC_SEN_B))
                       & (timebase_counter <= RFC_CNT_ONE);
  // Sensor B exists only with DC drive
  assign sen_b_ok    = (osc_mode_sel == RFC_MODE_DC);
  // Starts need the operating clock, so a frozen halt refuses them
  assign start_ok    = clk_run & (phase == RFC_IDLE);

  // Start priority reference, A, B; a run ends on wrap, zero, abort or disable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase <= RFC_IDLE;
    else
    begin
      case (phase)
        RFC_IDLE:
        begin
          if (start_ok && ref_trig_set)
            phase <= RFC_REF;
          else if (start_ok && sena_trig_set)
            phase <= RFC_SEN_A;
          else if (start_ok && senb_trig_set && sen_b_ok)
            phase <= RFC_SEN_B;
        end
        RFC_REF:
        begin
          if (trig_abort || !module_enable || mc_wrap || tc_wrap)
            phase <= RFC_IDLE;
        end
        default:
        begin
          if (trig_abort || !module_enable || mc_wrap || tc_hit_zero)
            phase <= RFC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Measurement counter
  // ----------------------------------------
  // Sensor start clears the count; presets land only while idle and not frozen
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      measurement_counter <= RFC_MC_RST;
    else if (start_ok && !ref_trig_set &&
             (sena_trig_set || (senb_trig_set && sen_b_ok)))
      measurement_counter <= RFC_CNT_ZERO;
    else if (phase == RFC_IDLE && preset.mc_wr && !frozen)
      measurement_counter <= preset.mc_data;
    else if (mc_tick)
      measurement_counter <= measurement_counter + RFC_CNT_ONE;
  end

  // ----------------------------------------
  // Time base counter
  // ----------------------------------------
  // Stops at zero on the sensor end so the value stays meaningful
  // Decrement is blocked at zero, so a late tick cannot wrap the value
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      timebase_counter <= RFC_TC_RST;
    else if (phase == RFC_IDLE && preset.tc_wr && !frozen)
      timebase_counter <= preset.tc_data;
    else if (tc_tick && phase == RFC_REF)
      timebase_counter <= timebase_counter + RFC_CNT_ONE;
    else if (tc_tick && timebase_counter != RFC_CNT_ZERO)
      timebase_counter <= timebase_counter - RFC_CNT_ONE;
  end

  // ----------------------------------------
  // Event flags and interrupt
  // ----------------------------------------
  rfc_evt_t evt;

  // Events decoded from the wrap and zero conditions of the running phase
  always_comb
  begin
    evt               = '0;
    evt.ref_done      = (phase == RFC_REF) & mc_wrap;
    evt.timebase_ovf  = (phase == RFC_REF) & tc_wrap & ~mc_wrap;
    evt.sensor_a_done = (phase == RFC_SEN_A) & tc_hit_zero & ~mc_wrap;
    evt.sensor_b_done = (phase == RFC_SEN_B) & tc_hit_zero & ~mc_wrap;
    evt.meas_ovf      = (phase == RFC_SEN_A || phase == RFC_SEN_B) & mc_wrap;
  end

  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      flags <= '0;
    else
      flags <= evt | (flags & ~flag_clear);
  end

  // Request uses the flag value being written, so it rises with the flag
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |((evt | (flags & ~flag_clear)) & irq_enable);
  end

  // ----------------------------------------
  // Trigger bits and pin drive
  // ----------------------------------------
  // Trigger bits trail the phase by one cycle, as software reads them
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_osc_trigger  <= 1'b0;
      sensor_a_trigger <= 1'b0;
      sensor_b_trigger <= 1'b0;
    end
    else
    begin
      ref_osc_trigger  <= (phase == RFC_REF);
      sensor_a_trigger <= (phase == RFC_SEN_A);
      sensor_b_trigger <= (phase == RFC_SEN_B);
    end
  end

  // Element drive mirrors the triggers; only one element oscillates at a time
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_resistor_pin <= 1'b0;
      sensor_a_pin     <= 1'b0;
      sensor_b_pin     <= 1'b0;
    end
    else
    begin
      ref_resistor_pin <= (phase == RFC_REF);
      sensor_a_pin     <= (phase == RFC_SEN_A);
      sensor_b_pin     <= (phase == RFC_SEN_B);
    end
  end

  // Monitor pin holds its level in a frozen halt; low outside a conversion
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_monitor_out_pin <= 1'b0;
    else if (!frozen)
      osc_monitor_out_pin <= (phase != RFC_IDLE) & osc_count_clock;
  end

endmodule : rfc_ctrl

// File: verification/rfc_ctrl_monitor.sv
`timescale 1ns/1ps
module rfc_ctrl_monitor
  import rfc_pkg::*;
(
  input wire logic                 clk,                 // Clock
  input wire logic                 sys_rst,             // Reset
  input wire logic                 module_enable,       // Enable
  input wire logic                 debug_run_en,        // Run in halt
  input wire logic                 cpu_debug_halt,      // Halt
  input wire logic [1:0]           osc_mode_sel,        // Mode
  input wire logic                 ref_trig_set,        // Ref start
  input wire logic                 trig_abort,          // Abort
  input wire rfc_preset_t          preset,              // Presets
  input wire rfc_evt_t             flag_clear,          // Clears
  input wire rfc_evt_t             irq_enable,          // Enables
  input wire logic                 ref_osc_trigger,     // Ref running
  input wire logic                 sensor_a_trigger,    // A running
  input wire logic                 sensor_b_trigger,    // B running
  input wire logic [RFC_CNT_W-1:0] measurement_counter, // Count
  input wire logic [RFC_CNT_W-1:0] timebase_counter,    // Time base
  input wire rfc_evt_t             flags,               // Flags
  input wire logic                 irq                  // Request
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  logic frz;     // Halt without run
  logic any_run; // Some phase visible
  assign frz     = cpu_debug_halt & ~debug_run_en;
  assign any_run = ref_osc_trigger | sensor_a_trigger | sensor_b_trigger;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Start pulse, then proof that the phase was idle when it came
  sequence ref_req;
    ref_trig_set && module_enable && !frz && !trig_abort;
  endsequence
  sequence idle_go;
    !any_run && module_enable && !frz && !trig_abort;
  endsequence

  ref_start_a: assert property (ref_req ##1 idle_go |=> ref_osc_trigger)
    else $error("reference start not seen");
  irq_follow_a: assert property (irq == |(flags & $past(irq_enable)))
    else $error("request does not follow flags");
  flag_sticky_a: assert property ((($past(flags) & ~$past(flag_clear)) & ~flags) == 5'h00)
    else $error("flag lost without clear");
  ref_done_a: assert property ($rose(flags.ref_done) |->
      ref_osc_trigger && measurement_counter < 24'h000004)
    else $error("reference done without count wrap");
  sen_done_a: assert property ($rose(flags.sensor_a_done) |->
      sensor_a_trigger && timebase_counter == RFC_CNT_ZERO)
    else $error("sensor done before time base zero");
  senb_mode_a: assert property ($rose(sensor_b_trigger) |-> $past(osc_mode_sel, 2) == RFC_MODE_DC)
    else $error("sensor B started outside DC mode");
  debug_freeze_a: assert property (frz [*2] |=> $stable(measurement_counter) &&
      $stable(timebase_counter) && $stable(flags))
    else $error("state moved in debug halt");
  preset_load_a: assert property ((preset.mc_wr && preset.tc_wr && !frz) ##1 idle_go |->
      measurement_counter == $past(preset.mc_data) && timebase_counter == $past(preset.tc_data))
    else $error("idle preset not loaded");
endmodule : rfc_ctrl_monitor

bind rfc_ctrl rfc_ctrl_monitor rfc_ctrl_monitor_inst (.clk, .sys_rst, .module_enable,
  .debug_run_en, .cpu_debug_halt, .osc_mode_sel, .ref_trig_set, .trig_abort, .preset,
  .flag_clear, .irq_enable, .ref_osc_trigger, .sensor_a_trigger, .sensor_b_trigger,
  .measurement_counter, .timebase_counter, .flags, .irq);

// File: verification/rfc_osc_model.sv
`timescale 1ns/1ps
module rfc_osc_model (
  input wire logic       run,          // Element driven
  input wire logic       ext_en,       // External pulse mode
  input wire logic [7:0] half_ns,      // Half period in ns
  output logic           rc_osc_clock, // RC oscillation
  output logic           osc_input_pin // External pulses
);
  // ----------------------------------------
  // Oscillation source
  // ----------------------------------------
  logic osc = 1'b0;

  // Stands still low outside a frame, like a stopped RC loop
  always #(half_ns) osc = run ? ~osc : 1'b0;
  // Only the selected source moves; the other idles low
  assign rc_osc_clock  = ext_en ? 1'b0 : osc;
  assign osc_input_pin = ext_en ? osc : 1'b0;
endmodule : rfc_osc_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rfc_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic        clk = 1'b0, sys_rst = 1'b1, module_enable = 1'b0, irq;
  logic        debug_run_en = 1'b0, cpu_debug_halt = 1'b0, ext_clock_input_en = 1'b0;
  logic        ref_trig_set = 1'b0, sena_trig_set = 1'b0, senb_trig_set = 1'b0;
  logic        trig_abort = 1'b0, rc_osc_clock, osc_input_pin, osc_monitor_out_pin;
  logic [1:0]  op_clock_source_sel = 2'h0, op_clock_divider_sel = 2'h0, osc_mode_sel = 2'h0;
  logic [7:0]  half = 8'h10;
  rfc_preset_t preset = '0;
  rfc_evt_t    flag_clear = '0, irq_enable = '0, flags;
  logic        ref_osc_trigger, sensor_a_trigger, sensor_b_trigger;
  logic        ref_resistor_pin, sensor_a_pin, sensor_b_pin;
  logic [23:0] measurement_counter, timebase_counter, m, tsave;
  int          seed = 32'h3667, mismatches = 0, samples_checked = 0, k, h1, h2, s;

  always #4 clk = ~clk;

  rfc_ctrl rfc_ctrl_inst (.clk, .sys_rst, .module_enable, .op_clock_source_sel,
    .op_clock_divider_sel, .debug_run_en, .cpu_debug_halt, .osc_mode_sel,
    .ext_clock_input_en, .rc_osc_clock, .osc_input_pin, .ref_trig_set, .sena_trig_set,
    .senb_trig_set, .trig_abort, .preset, .flag_clear, .irq_enable, .ref_osc_trigger,
    .sensor_a_trigger, .sensor_b_trigger, .ref_resistor_pin, .sensor_a_pin, .sensor_b_pin,
    .osc_monitor_out_pin, .measurement_counter, .timebase_counter, .flags, .irq);
  // Oscillates only while the design drives an element pin
  rfc_osc_model rfc_osc_model_inst (.run(ref_resistor_pin | sensor_a_pin | sensor_b_pin),
    .ext_en(ext_clock_input_en), .half_ns(half), .rc_osc_clock, .osc_input_pin);

  // Inputs always move 1 ns after the edge
  task automatic tk(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk

  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got,
                     input int tol = 0);
    samples_checked++;
    if ($isunknown(got) || (got > ex ? got - ex : ex - got) > tol)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk

  // One-cycle strobe: 0 ref, 1 sensor A, 2 sensor B, 3 abort
  task automatic pulse(input int w);
    {trig_abort, senb_trig_set, sena_trig_set, ref_trig_set} = 4'h1 << w;
    tk();
    {trig_abort, senb_trig_set, sena_trig_set, ref_trig_set} = 4'h0;
  endtask : pulse

  // Counter presets and flag clears go in one idle cycle
  task automatic prep(input logic [23:0] n, input logic [23:0] t);
    preset = '{1'b1, n, 1'b1, t};
    flag_clear = 5'h1F;
    tk();
    preset = '0;
    flag_clear = 5'h00;
    tk();
  endtask : prep

  // Bounded wait; running out counts as a mismatch
  task automatic wait_flag(input logic [4:0] msk);
    int n;
    n = 0;
    while ((flags & msk) === 5'h00 && n < 20000)
    begin
      tk();
      n++;
    end
    if (n == 20000)
      mismatches++;
    tk(2);
  endtask : wait_flag

  function automatic logic [23:0] scale(input int n, input int num, input int den);
    return 24'(n * num / den);
  endfunction : scale

  // A running counter is read until two reads in a row agree
  task automatic rd2(output logic [23:0] v);
    int n;
    n = 0;
    v = measurement_counter;
    tk();
    while (v !== measurement_counter && n < 8)
    begin
      v = measurement_counter;
      tk();
      n++;
    end
  endtask : rd2

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Watchdog sized well above the whole sequence
  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end

  // Main sequence: random conversions, then refusals, halt and time base wrap
  initial
  begin
    tk(6);
    sys_rst = 1'b0;
    chk("reset", 24'h0, measurement_counter | timebase_counter | 24'(flags));
    module_enable = 1'b1;
    tk();
    for (int i = 0; i < 4; i++)
    begin
      k = 32 + ($random(seed) & 63);
      h1 = 12 + ($random(seed) & 15);
      h2 = 12 + ($random(seed) & 15);
      op_clock_source_sel = 2'($random(seed) & 1);
      op_clock_divider_sel = 2'($random(seed) & 1);
      s = op_clock_source_sel + op_clock_divider_sel;
      irq_enable = 5'($random(seed));
      osc_mode_sel = i[0] ? RFC_MODE_AC : RFC_MODE_DC;
      ext_clock_input_en = (i == 3);
      half = 8'(h1);
      prep(24'(32'h1000000 - k), RFC_CNT_ZERO);
      pulse(0);
      wait_flag(5'h11);
      chk("ref_done", 24'h1, 24'(flags.ref_done));
      chk("ref_stop", 24'h0, 24'(ref_osc_trigger));
      chk("ref_irq", 24'(irq_enable.ref_done), 24'(irq));
      chk("ref_span", scale(k, 2 * h1, 8 << s), timebase_counter, 6);
      tsave = timebase_counter;
      flag_clear = 5'h1F;
      tk();
      flag_clear = 5'h00;
      half = 8'(h2);
      pulse((i == 2) ? 2 : 1);
      wait_flag(5'h0E);
      chk("sen_done", 24'h1, 24'((i == 2) ? flags.sensor_b_done : flags.sensor_a_done));
      chk("sen_base", RFC_CNT_ZERO, timebase_counter);
      chk("sen_count", scale(k, h1, h2), measurement_counter, 5);
      if (i == 1)
      begin
        prep(RFC_CNT_ZERO, tsave);
        pulse(1);
        wait_flag(5'h0E);
        chk("reuse_count", scale(k, h1, h2), measurement_counter, 5);
      end
    end
    $display("test conversions done");
    pulse(2);
    tk(3);
    chk("b_in_ac", 24'h0, 24'(sensor_b_trigger));
    prep(RFC_CNT_ZERO, RFC_CNT_ZERO);
    pulse(0);
    tk();
    pulse(1);
    tk(3);
    chk("busy", 24'h1, 24'({sensor_a_trigger, ref_osc_trigger}));
    chk("ref_pin", 24'h1, 24'(ref_resistor_pin));
    cpu_debug_halt = 1'b1;
    tk(2);
    rd2(m);
    s = osc_monitor_out_pin;
    tk(30);
    chk("halt_hold", m, measurement_counter);
    chk("pin_hold", 24'(s), 24'(osc_monitor_out_pin));
    debug_run_en = 1'b1;
    s = 0;
    repeat (30)
    begin
      tk();
      s += osc_monitor_out_pin;
    end
    chk("mon_duty", 24'h0F, 24'(s), 4);
    chk("halt_run", m + scale(30, 8, 2 * h2), measurement_counter, 3);
    cpu_debug_halt = 1'b0;
    pulse(3);
    tk(3);
    // Time base wraps long before the count would
    prep(RFC_CNT_ZERO, 24'hFFFFF0);
    pulse(0);
    wait_flag(5'h11);
    chk("tb_ovf", 24'h1, 24'({flags.ref_done, flags.timebase_ovf}));
    chk("mon_idle", 24'h0, 24'(osc_monitor_out_pin));
    $display("test corners done");
    close_out();
  end
endmodule : tb_top
